// ---- core/swrs_engine.sv ----
// command engine: block read, rom search, full command-start sequence
`timescale 1ns/1ps
module swrs_engine #(
  parameter int unsigned HOLD_STEP_CYC = swrs_pkg::HOLD_STEP_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // host command
  input  wire logic       cmd_start,
  input  wire logic [7:0] cmd_code,
  input  wire logic [7:0] cmd_param,
  input  wire logic [7:0] cmd_len,
  input  wire logic       overdrive,
  // host payload buffer
  input  wire logic       pay_we,
  input  wire logic [6:0] pay_addr,
  input  wire logic [7:0] pay_data,
  // host response
  input  wire logic [6:0] resp_addr,
  output logic      [7:0] resp_data,
  output logic            busy,
  output logic            done,
  // bus primitive link
  output logic            ow_req,
  output logic      [3:0] ow_op,
  output logic      [7:0] ow_wdata,
  output logic            ow_speed,
  output logic            strong_pullup,
  input  wire logic       ow_done,
  input  wire logic [7:0] ow_rdata,
  input  wire logic       ow_presence,
  input  wire logic       ow_fail
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rs_q;
  logic       srst_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rs_q <= 2'b00;
    else rs_q <= {rs_q[0], 1'b1};
  end
  assign srst_n = rs_q[1];

  // ----------------------------------------
  // state
  // ----------------------------------------
  swrs_pkg::swrs_state_t st_q;
  swrs_pkg::swrs_phase_t ph_q;
  logic [6:0]  idx_q;
  logic [7:0]  rem_q, cmd_q, param_q, len_q, rlen_q, code_q, resp_len_q, wptr_q;
  logic        ign_q, srch_q, final_q;
  logic [7:0]  steps_q;
  logic [23:0] cyc_q;
  logic [63:0] rom_q;
  logic [6:0]  last_disc_q, lz_q, lz_n;
  logic [15:0] crc_q, crc_n;
  logic [7:0]  tx_mem [0:127];
  logic [7:0]  rx_mem [0:127];
  logic        take, start, dir_n, trip_none, rx_ph;
  logic [7:0]  wd_n;
  swrs_pkg::swrs_op_t op_n;

  assign take      = (st_q == swrs_pkg::S_WAIT) && ow_done;
  assign start     = (st_q == swrs_pkg::S_IDLE) && cmd_start;
  assign trip_none = ow_rdata[0] & ow_rdata[1];
  assign crc_n     = swrs_pkg::crc16(crc_q, ow_rdata);
  assign lz_n      = (!ow_rdata[0] && !ow_rdata[1] && !ow_rdata[2]) ? idx_q : lz_q;
  assign dir_n     = (idx_q < last_disc_q) ? rom_q[6'(idx_q - 7'h01)]
                                           : (idx_q == last_disc_q);
  assign rx_ph     = ph_q inside {swrs_pkg::P_CRC1, swrs_pkg::P_RLEN,
                                  swrs_pkg::P_RDATA, swrs_pkg::P_CRC2};

  // ----------------------------------------
  // next bus operation
  // ----------------------------------------
  always_comb begin
    op_n = swrs_pkg::OP_WRITE;
    wd_n = 8'h00;
    unique case (ph_q)
      swrs_pkg::P_RST:   op_n = swrs_pkg::OP_RESET;
      swrs_pkg::P_SCMD:  wd_n = swrs_pkg::BUS_SEARCH;
      swrs_pkg::P_TRIP: begin
        op_n = swrs_pkg::OP_TRIP;
        wd_n = {7'h00, dir_n};
      end
      swrs_pkg::P_MATCH: wd_n = swrs_pkg::BUS_MATCH;
      swrs_pkg::P_ID:    wd_n = tx_mem[idx_q];
      swrs_pkg::P_START: wd_n = swrs_pkg::BUS_START;
      swrs_pkg::P_LEN:   wd_n = len_q;
      swrs_pkg::P_PAY:   wd_n = tx_mem[7'(idx_q + swrs_pkg::PAY_BASE)];
      swrs_pkg::P_REL:   wd_n = swrs_pkg::BUS_RELEASE;
      swrs_pkg::P_CRC1, swrs_pkg::P_DUMMY, swrs_pkg::P_RLEN, swrs_pkg::P_RDATA,
      swrs_pkg::P_CRC2:  op_n = swrs_pkg::OP_READ;
    endcase
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  task automatic fin(input logic [7:0] c, input logic [7:0] l);
    st_q       <= swrs_pkg::S_IDLE;
    busy       <= 1'b0;
    done       <= 1'b1;
    code_q     <= c;
    resp_len_q <= l;
  endtask

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      st_q <= swrs_pkg::S_IDLE;
      ph_q <= swrs_pkg::P_RST;
      idx_q <= 7'h00;
      {rem_q, cmd_q, param_q, len_q, rlen_q} <= 40'h00_0000_0000;
      code_q <= 8'h00;
      resp_len_q <= 8'h00;
      wptr_q <= 8'h00;
      {ign_q, srch_q, busy, done} <= 4'h0;
      steps_q <= 8'h00;
      cyc_q <= 24'h00_0000;
    end else begin
      done <= 1'b0;
      unique case (st_q)
        swrs_pkg::S_IDLE: if (cmd_start) begin
          {cmd_q, param_q, len_q, rem_q} <= {cmd_code, cmd_param, cmd_len, cmd_param};
          busy   <= 1'b1;
          idx_q  <= 7'h00;
          wptr_q <= swrs_pkg::RX_BASE;
          srch_q <= cmd_code == swrs_pkg::CMD_SEARCH;
          ign_q  <= cmd_param[1];
          st_q   <= swrs_pkg::S_ISSUE;
          if (cmd_code == swrs_pkg::CMD_READ) begin
            ph_q <= swrs_pkg::P_RDATA;
            if (cmd_param == 8'h00 || cmd_param > swrs_pkg::MAX_READ)
              fin(swrs_pkg::RES_BADPAR, swrs_pkg::LEN_FAIL);
          end else if (cmd_code == swrs_pkg::CMD_SEARCH) begin
            if (|cmd_param[7:3]) fin(swrs_pkg::RES_BADPAR, swrs_pkg::LEN_FAIL);
            ph_q <= cmd_param[0] ? swrs_pkg::P_RST : swrs_pkg::P_SCMD;
          end else if (cmd_code == swrs_pkg::CMD_FULL) begin
            ph_q  <= swrs_pkg::P_RST;
            ign_q <= 1'b1;
          end else begin
            fin(swrs_pkg::RES_BADPAR, swrs_pkg::LEN_FAIL);
          end
        end
        swrs_pkg::S_ISSUE: st_q <= swrs_pkg::S_WAIT;
        swrs_pkg::S_HOLD: begin
          if (cyc_q == 24'h00_0000) begin
            if (steps_q == 8'h01) begin
              st_q <= swrs_pkg::S_ISSUE;
              ph_q <= swrs_pkg::P_DUMMY;
            end else begin
              steps_q <= 8'(steps_q - 8'h01);
              cyc_q   <= 24'(HOLD_STEP_CYC - 1);
            end
          end else begin
            cyc_q <= 24'(cyc_q - 24'h00_0001);
          end
        end
        swrs_pkg::S_WAIT: if (ow_done) begin
          st_q <= swrs_pkg::S_ISSUE;
          if (ow_fail && cmd_q == swrs_pkg::CMD_READ) begin
            fin(swrs_pkg::RES_COMM, swrs_pkg::LEN_FAIL);
          end else begin
            unique case (ph_q)
              swrs_pkg::P_RST:
                if (!ow_presence && !ign_q) fin(swrs_pkg::RES_NOPRES, swrs_pkg::LEN_FAIL);
                else ph_q <= srch_q ? swrs_pkg::P_SCMD : swrs_pkg::P_MATCH;
              swrs_pkg::P_SCMD: begin
                ph_q  <= swrs_pkg::P_TRIP;
                idx_q <= 7'h01;
              end
              swrs_pkg::P_TRIP:
                if (trip_none) fin(swrs_pkg::RES_NONE, swrs_pkg::LEN_FAIL);
                else if (idx_q == swrs_pkg::SEARCH_BITS)
                  fin(swrs_pkg::RES_OK, swrs_pkg::LEN_SEARCH);
                else idx_q <= 7'(idx_q + 7'h01);
              swrs_pkg::P_MATCH: begin
                ph_q  <= swrs_pkg::P_ID;
                idx_q <= 7'h00;
              end
              swrs_pkg::P_ID:
                if (idx_q == swrs_pkg::ID_LAST) ph_q <= swrs_pkg::P_START;
                else idx_q <= 7'(idx_q + 7'h01);
              swrs_pkg::P_START: ph_q <= swrs_pkg::P_LEN;
              swrs_pkg::P_LEN: begin
                ph_q  <= (len_q == 8'h00) ? swrs_pkg::P_CRC1 : swrs_pkg::P_PAY;
                idx_q <= 7'h00;
              end
              swrs_pkg::P_PAY:
                if ({1'b0, idx_q} == 8'(len_q - 8'h01)) begin
                  ph_q  <= swrs_pkg::P_CRC1;
                  idx_q <= 7'h00;
                end else idx_q <= 7'(idx_q + 7'h01);
              swrs_pkg::P_CRC1:
                if (idx_q == 7'h00) idx_q <= 7'h01;
                else if (crc_n == swrs_pkg::CRC_RESIDUAL) ph_q <= swrs_pkg::P_REL;
                else fin(swrs_pkg::RES_NONE, swrs_pkg::LEN_FAIL);
              swrs_pkg::P_REL:
                if (param_q == 8'h00) ph_q <= swrs_pkg::P_DUMMY;
                else begin
                  st_q    <= swrs_pkg::S_HOLD;
                  steps_q <= param_q;
                  cyc_q   <= 24'(HOLD_STEP_CYC - 1);
                end
              swrs_pkg::P_DUMMY: ph_q <= swrs_pkg::P_RLEN;
              swrs_pkg::P_RLEN: begin
                rem_q  <= ow_rdata;
                rlen_q <= ow_rdata;
                idx_q  <= 7'h00;
                ph_q   <= (ow_rdata == 8'h00) ? swrs_pkg::P_CRC2 : swrs_pkg::P_RDATA;
              end
              swrs_pkg::P_RDATA:
                if (rem_q != 8'h01) rem_q <= 8'(rem_q - 8'h01);
                else if (cmd_q == swrs_pkg::CMD_READ)
                  fin(swrs_pkg::RES_OK, 8'(param_q + 8'h01));
                else begin
                  ph_q  <= swrs_pkg::P_CRC2;
                  idx_q <= 7'h00;
                end
              swrs_pkg::P_CRC2:
                if (idx_q == 7'h00) idx_q <= 7'h01;
                else if (crc_n == swrs_pkg::CRC_RESIDUAL)
                  fin(swrs_pkg::RES_OK, 8'(rlen_q + 8'h02));
                else fin(swrs_pkg::RES_NONE, swrs_pkg::LEN_FAIL);
            endcase
          end
        end
      endcase
      if (take && rx_ph && ph_q != swrs_pkg::P_CRC1) wptr_q <= 8'(wptr_q + 8'h01);
    end
  end

  // ----------------------------------------
  // link outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      ow_req <= 1'b0;
      ow_op <= swrs_pkg::OP_RESET;
      ow_wdata <= 8'h00;
      ow_speed <= 1'b0;
      strong_pullup <= 1'b0;
    end else begin
      ow_req   <= st_q == swrs_pkg::S_ISSUE;
      ow_speed <= overdrive;
      if (st_q == swrs_pkg::S_ISSUE) begin
        ow_op    <= op_n;
        ow_wdata <= wd_n;
        if (ph_q == swrs_pkg::P_REL) strong_pullup <= 1'b1;
      end
      // dropped when the hold runs out, or right after release with no hold
      if ((take && ph_q == swrs_pkg::P_REL && param_q == 8'h00) ||
          (st_q == swrs_pkg::S_HOLD && cyc_q == 24'h00_0000 && steps_q == 8'h01))
        strong_pullup <= 1'b0;
    end
  end

  // ----------------------------------------
  // search state
  // ----------------------------------------
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      rom_q <= 64'h0000_0000_0000_0000;
      last_disc_q <= 7'h00;
      lz_q <= 7'h00;
      final_q <= 1'b0;
    end else if (start) begin
      lz_q <= 7'h00;
      // a finished walk restarts from the first slave
      if (cmd_code != swrs_pkg::CMD_SEARCH || cmd_param[2] || final_q) begin
        last_disc_q <= 7'h00;
        final_q     <= 1'b0;
      end
    end else if (take && ph_q == swrs_pkg::P_TRIP) begin
      if (trip_none) begin
        last_disc_q <= 7'h00;
        final_q     <= 1'b0;
      end else begin
        rom_q[6'(idx_q - 7'h01)] <= ow_rdata[2];
        lz_q <= lz_n;
        if (idx_q == swrs_pkg::SEARCH_BITS) begin
          last_disc_q <= lz_n;
          final_q     <= lz_n == 7'h00;
        end
      end
    end
  end

  // ----------------------------------------
  // crc16 over the start, length and payload bytes written and the bytes read back
  // ----------------------------------------
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) crc_q <= swrs_pkg::CRC_INIT;
    else if (start || (take && ph_q == swrs_pkg::P_DUMMY)) crc_q <= swrs_pkg::CRC_INIT;
    else if (take && (rx_ph || ph_q inside {swrs_pkg::P_START, swrs_pkg::P_LEN,
                                            swrs_pkg::P_PAY}))
      crc_q <= swrs_pkg::crc16(crc_q, rx_ph ? ow_rdata : ow_wdata);
  end

  // ----------------------------------------
  // buffers and response port
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (pay_we) tx_mem[pay_addr] <= pay_data;
  end

  always_ff @(posedge clk) begin
    if (take && (ph_q inside {swrs_pkg::P_RLEN, swrs_pkg::P_RDATA}) && !wptr_q[7])
      rx_mem[wptr_q[6:0]] <= ow_rdata;
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) resp_data <= 8'h00;
    else if (resp_addr == 7'h00) resp_data <= resp_len_q;
    else if (resp_addr == 7'h01) resp_data <= code_q;
    else if (srch_q && resp_addr == swrs_pkg::FLAG_ADDR) resp_data <= {7'h00, final_q};
    else if (srch_q && resp_addr < swrs_pkg::FLAG_ADDR)
      resp_data <= rom_q[{3'(resp_addr[2:0] - 3'h2), 3'h0} +: 8];
    else resp_data <= rx_mem[resp_addr];
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!srst_n);

  sequence s_crc2_last;
    take && ph_q == swrs_pkg::P_CRC2 && idx_q != 7'h00;
  endsequence
  sequence s_full_go;
    start && cmd_code == swrs_pkg::CMD_FULL;
  endsequence

  property p_bad_search;
    start && cmd_code == swrs_pkg::CMD_SEARCH && |cmd_param[7:3]
      |=> done && code_q == swrs_pkg::RES_BADPAR ##1 !ow_req;
  endproperty
  a_bad_search: assert property (p_bad_search) else $error("bad search param not refused");

  property p_no_presence;
    take && ph_q == swrs_pkg::P_RST && !ow_presence && !ign_q
      |=> done && code_q == swrs_pkg::RES_NOPRES;
  endproperty
  a_no_presence: assert property (p_no_presence) else $error("no presence not reported");

  property p_search_code;
    ow_req && ph_q == swrs_pkg::P_SCMD |-> ow_wdata == swrs_pkg::BUS_SEARCH;
  endproperty
  a_search_code: assert property (p_search_code) else $error("wrong search byte");

  property p_full_reset;
    s_full_go |-> ##2 ow_req && ow_op == swrs_pkg::OP_RESET;
  endproperty
  a_full_reset: assert property (p_full_reset) else $error("no opening reset");

  property p_spu_release;
    $rose(strong_pullup) |-> ow_req && ow_wdata == swrs_pkg::BUS_RELEASE;
  endproperty
  a_spu_release: assert property (p_spu_release) else $error("pullup not with release");

  property p_release_crc;
    $rose(ph_q == swrs_pkg::P_REL) |-> $past(crc_n) == swrs_pkg::CRC_RESIDUAL;
  endproperty
  a_release_crc: assert property (p_release_crc) else $error("release without good crc");

  property p_crc2_bad;
    s_crc2_last ##0 crc_n != swrs_pkg::CRC_RESIDUAL |=> done && code_q == swrs_pkg::RES_NONE;
  endproperty
  a_crc2_bad: assert property (p_crc2_bad) else $error("result crc error missed");

  property p_final;
    done && srch_q && code_q == swrs_pkg::RES_OK |-> final_q == (last_disc_q == 7'h00);
  endproperty
  a_final: assert property (p_final) else $error("final flag wrong");

  property p_read_byte_count;
    done && cmd_q == swrs_pkg::CMD_READ && code_q == swrs_pkg::RES_OK
      |-> resp_len_q == 8'(param_q + 8'h01);
  endproperty
  a_read_byte_count: assert property (p_read_byte_count) else $error("read length wrong");

  property p_hold_spu;
    st_q == swrs_pkg::S_HOLD |-> strong_pullup && busy;
  endproperty
  a_hold_spu: assert property (p_hold_spu) else $error("pullup dropped in hold");

endmodule

// ---- core/swrs_pkg.sv ----
// constants, types and crc helper for the single-wire read/search/sequence engine
package swrs_pkg;

  // ----------------------------------------
  // host command codes and result codes
  // ----------------------------------------
  localparam logic [7:0] CMD_READ   = 8'h50;
  localparam logic [7:0] CMD_SEARCH = 8'h11;
  localparam logic [7:0] CMD_FULL   = 8'h57;
  localparam logic [7:0] RES_OK     = 8'hAA;
  localparam logic [7:0] RES_NONE   = 8'h00;
  localparam logic [7:0] RES_BADPAR = 8'h77;
  localparam logic [7:0] RES_COMM   = 8'h22;
  localparam logic [7:0] RES_NOPRES = 8'h33;

  // ----------------------------------------
  // bytes sent on the single-wire bus
  // ----------------------------------------
  localparam logic [7:0] BUS_SEARCH  = 8'h11;
  localparam logic [7:0] BUS_MATCH   = 8'h55;
  localparam logic [7:0] BUS_START   = 8'h66;
  localparam logic [7:0] BUS_RELEASE = 8'hAA;

  // ----------------------------------------
  // counts, offsets and reset values
  // ----------------------------------------
  localparam logic [7:0]  MAX_READ      = 8'h7E;
  localparam logic [6:0]  SEARCH_BITS   = 7'h40;
  localparam logic [6:0]  ID_LAST       = 7'h07;
  localparam logic [6:0]  PAY_BASE      = 7'h08;
  localparam logic [7:0]  RX_BASE       = 8'h02;
  localparam logic [7:0]  LEN_FAIL      = 8'h01;
  localparam logic [7:0]  LEN_SEARCH    = 8'h0A;
  localparam logic [6:0]  FLAG_ADDR     = 7'h0A;
  localparam logic [15:0] CRC_INIT      = 16'h0000;
  localparam logic [15:0] CRC_POLY      = 16'hA001;
  localparam logic [15:0] CRC_RESIDUAL  = 16'hB001;
  localparam int unsigned HOLD_STEP_MS  = 32'h0000_0002;
  localparam int unsigned CLK_FREQ_KHZ  = 32'h0003_D090;
  localparam int unsigned HOLD_STEP_CYC = HOLD_STEP_MS * CLK_FREQ_KHZ;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_RESET = 4'b0001, OP_WRITE = 4'b0010, OP_READ = 4'b0100, OP_TRIP = 4'b1000
  } swrs_op_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001, S_ISSUE = 4'b0010, S_WAIT = 4'b0100, S_HOLD = 4'b1000
  } swrs_state_t;

  typedef enum logic [13:0] {
    P_RST   = 14'h0001, P_SCMD  = 14'h0002, P_TRIP  = 14'h0004, P_MATCH = 14'h0008,
    P_ID    = 14'h0010, P_START = 14'h0020, P_LEN   = 14'h0040, P_PAY   = 14'h0080,
    P_CRC1  = 14'h0100, P_REL   = 14'h0200, P_DUMMY = 14'h0400, P_RLEN  = 14'h0800,
    P_RDATA = 14'h1000, P_CRC2  = 14'h2000
  } swrs_phase_t;

  // reflected crc16, one byte lsb first
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// ---- verification/swrs_bus_model.sv ----
// bus primitive agent holding one slave, far side of the engine
`timescale 1ns/1ps
module swrs_bus_model #(
  parameter logic [63:0] SLAVE_ID = 64'h1D2C_3B4A_5968_7786
) (
  // link
  input  wire logic       clk,
  input  wire logic       ow_req,
  input  wire logic [3:0] ow_op,
  input  wire logic [7:0] ow_wdata,
  output logic            ow_done,
  output logic      [7:0] ow_rdata,
  output logic            ow_presence,
  output logic            ow_fail,
  // scenario controls
  input  wire logic       clr,
  input  wire logic       slow,
  input  wire logic       present,
  input  wire logic       fail
);
  logic [7:0] rd_mem [0:127];
  logic [7:0] wr_log [0:31];
  logic [3:0] op_q;
  logic       pend = 1'b0;
  int         rd_i = 0;
  int         wr_n = 0;
  int         bit_i = 0;
  int         wait_c = 0;
  initial {ow_done, ow_rdata, ow_presence, ow_fail} = 11'h000;
  // released data toggles and presence/fail read inverted so stale values never look valid
  always @(posedge clk) begin
    ow_done <= 1'b0;
    ow_rdata <= ~ow_rdata;
    ow_presence <= ~present;
    ow_fail <= ~fail;
    if (clr) begin
      rd_i <= 0;
      wr_n <= 0;
    end else if (ow_req) begin
      pend <= 1'b1;
      op_q <= ow_op;
      wait_c <= slow ? 3 : 0;
      if (ow_op == swrs_pkg::OP_WRITE) begin
        wr_log[wr_n[4:0]] <= ow_wdata;
        wr_n <= wr_n + 1;
        bit_i <= 0;
      end
    end else if (pend && wait_c > 0) begin
      wait_c <= wait_c - 1;
    end else if (pend) begin
      pend <= 1'b0;
      ow_done <= 1'b1;
      ow_presence <= present;
      ow_fail <= fail;
      if (op_q == swrs_pkg::OP_READ) begin
        ow_rdata <= rd_mem[rd_i[6:0]];
        rd_i <= rd_i + 1;
      end
      if (op_q == swrs_pkg::OP_TRIP) begin
        ow_rdata <= {5'h00, SLAVE_ID[bit_i], ~SLAVE_ID[bit_i], SLAVE_ID[bit_i]};
        bit_i <= bit_i + 1;
      end
    end
  end
endmodule

// ---- verification/swrs_engine_test.sv ----
// self-checking bench for the read/search/sequence engine
`timescale 1ns/1ps
module swrs_engine_test;
  logic        clk, rst_n, cmd_start, overdrive, pay_we, busy, done, ow_req;
  logic        ow_speed, strong_pullup, ow_done, ow_presence, ow_fail;
  logic        clr, slow, present, fail;
  logic [7:0]  cmd_code, cmd_param, cmd_len, pay_data, resp_data, ow_wdata, ow_rdata;
  logic [6:0]  pay_addr, resp_addr;
  logic [3:0]  ow_op;
  logic [15:0] crc;
  int          failures, total_checks, sp_cyc;
  localparam logic [63:0] ID = 64'h1D2C_3B4A_5968_7786;
  typedef struct {logic [7:0] code, param; logic pres, fl; logic [7:0] res, len;} swrs_row_t;
  swrs_row_t rows [0:9] = '{
    '{8'h50, 8'h02, 1'b1, 1'b0, 8'hAA, 8'h03}, '{8'h50, 8'h7E, 1'b1, 1'b0, 8'hAA, 8'h7F},
    '{8'h50, 8'h00, 1'b1, 1'b0, 8'h77, 8'h01}, '{8'h50, 8'h7F, 1'b1, 1'b0, 8'h77, 8'h01},
    '{8'h50, 8'h01, 1'b1, 1'b1, 8'h22, 8'h01}, '{8'h11, 8'h04, 1'b1, 1'b0, 8'hAA, 8'h0A},
    '{8'h11, 8'h01, 1'b0, 1'b0, 8'h33, 8'h01}, '{8'h11, 8'h03, 1'b0, 1'b0, 8'hAA, 8'h0A},
    '{8'h11, 8'h08, 1'b1, 1'b0, 8'h77, 8'h01}, '{8'h13, 8'h00, 1'b1, 1'b0, 8'h77, 8'h01}};
  swrs_engine #(.HOLD_STEP_CYC(4)) dut (.clk(clk), .rst_n(rst_n), .cmd_start(cmd_start),
    .cmd_code(cmd_code), .cmd_param(cmd_param), .cmd_len(cmd_len), .overdrive(overdrive),
    .pay_we(pay_we), .pay_addr(pay_addr), .pay_data(pay_data), .resp_addr(resp_addr),
    .resp_data(resp_data), .busy(busy), .done(done), .ow_req(ow_req), .ow_op(ow_op),
    .ow_wdata(ow_wdata), .ow_speed(ow_speed), .strong_pullup(strong_pullup),
    .ow_done(ow_done), .ow_rdata(ow_rdata), .ow_presence(ow_presence), .ow_fail(ow_fail));
  swrs_bus_model #(.SLAVE_ID(ID)) bm (.clk(clk), .ow_req(ow_req), .ow_op(ow_op),
    .ow_wdata(ow_wdata), .ow_done(ow_done), .ow_rdata(ow_rdata), .ow_presence(ow_presence),
    .ow_fail(ow_fail), .clr(clr), .slow(slow), .present(present), .fail(fail));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [63:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // host side never starts a command before done, so no start is ignored while busy
  task automatic run(input logic [7:0] code, param, len);
    int n;
    n = 0;
    @(negedge clk);
    {cmd_code, cmd_param, cmd_len, cmd_start} = {code, param, len, 1'b1};
    @(negedge clk);
    cmd_start = 1'b0;
    while (done !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 20000) begin
        check("done wait", 0, 1);
        end_sim();
      end
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    @(negedge clk);
    resp_addr = a;
    @(negedge clk);
    check($sformatf("response byte %0d", a), resp_data, exp);
  endtask
  task automatic load(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    {pay_we, pay_addr, pay_data} = {1'b1, a, d};
    @(negedge clk);
    pay_we = 1'b0;
  endtask
  function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    return c;
  endfunction
  always @(posedge clk) if (strong_pullup === 1'b1) sp_cyc <= sp_cyc + 1;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    {rst_n, cmd_start, overdrive, pay_we, clr, slow, fail, present} = 8'h01;
    {cmd_code, cmd_param, cmd_len, pay_data, pay_addr, resp_addr} = 46'h0;
    {failures, total_checks, sp_cyc} = 96'h0;
    for (int i = 0; i < 128; i++) bm.rd_mem[i] = 8'h30 + 8'(i);
    repeat (6) @(negedge clk);
    check("reset outputs", {busy, done, ow_req, strong_pullup, ow_op}, 8'h01);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    $display("reset test done");
    foreach (rows[i]) begin
      {present, fail, clr} = {rows[i].pres, rows[i].fl, 1'b1};
      {overdrive, slow} = {1'(i % 2), 1'(i % 3 == 0)};
      @(negedge clk);
      clr = 1'b0;
      run(rows[i].code, rows[i].param, 8'h00);
      rchk(7'h01, rows[i].res);
      rchk(7'h00, rows[i].len);
      check("speed", ow_speed, overdrive);
      if (rows[i].res == 8'h77) check("bus traffic", bm.wr_n + bm.rd_i, 0);
      if (rows[i].code == 8'h50 && rows[i].res == 8'hAA) begin
        rchk(7'h02, 8'h30);
        rchk(7'h03, 8'h31);
      end
      if (rows[i].code == 8'h11 && rows[i].res == 8'hAA) begin
        check("search code", bm.wr_log[0], 8'h11);
        for (int k = 0; k < 8; k++) rchk(7'(k + 2), ID[8*k +: 8]);
        rchk(7'h0A, 8'h01);
      end
      $display("row %0d done", i);
    end
    for (int i = 0; i < 8; i++) load(7'(i), ID[8*i +: 8]);
    load(7'h08, 8'hC3);
    load(7'h09, 8'h5A);
    for (int bad = 0; bad < 3; bad++) begin
      crc = step(step(step(step(16'h0000, 8'h66), 8'h02), 8'hC3), 8'h5A);
      bm.rd_mem[0] = ~crc[7:0] ^ 8'(bad == 1);
      bm.rd_mem[1] = ~crc[15:8];
      {bm.rd_mem[2], bm.rd_mem[3], bm.rd_mem[4]} = 24'hE7_019C;
      crc = step(step(16'h0000, 8'h01), 8'h9C);
      bm.rd_mem[5] = ~crc[7:0] ^ 8'(bad == 2);
      bm.rd_mem[6] = ~crc[15:8];
      {clr, present, slow} = {1'b1, 1'b0, 1'(bad)};
      @(negedge clk);
      {clr, sp_cyc} = 33'h0;
      run(8'h57, 8'h02, 8'h02);
      rchk(7'h01, bad == 0 ? 8'hAA : 8'h00);
      check("write count", bm.wr_n, bad == 1 ? 13 : 14);
      check("match code", bm.wr_log[0], 8'h55);
      for (int k = 0; k < 8; k++) check("id byte", bm.wr_log[k + 1], ID[8*k +: 8]);
      check("start and length", {bm.wr_log[9], bm.wr_log[10]}, 16'h6602);
      check("payload", {bm.wr_log[11], bm.wr_log[12]}, 16'hC35A);
      if (bad != 1) check("release", bm.wr_log[13], 8'hAA);
      if (bad != 1) check("pullup time", sp_cyc >= 8 && sp_cyc <= 16, 1);
      check("pullup off", strong_pullup, 1'b0);
      if (bad == 0) begin
        rchk(7'h00, 8'h03);
        rchk(7'h02, 8'h01);
        rchk(7'h03, 8'h9C);
      end
      $display("sequence case %0d done", bad);
    end
    // reset in mid-command: a stale agent answer must not leak into the next command
    slow = 1'b1;
    @(negedge clk);
    {cmd_code, cmd_param, cmd_start} = {8'h50, 8'h05, 1'b1};
    @(negedge clk);
    cmd_start = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    check("mid-run reset outputs", {busy, done, ow_req, strong_pullup, ow_op}, 8'h01);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    run(8'h50, 8'h01, 8'h00);
    rchk(7'h01, 8'hAA);
    rchk(7'h00, 8'h02);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule
